// ===== inc/lsbd_params.svh
/*
 Constants of the logic, string and branch decoder: opcode codes,
 group fields and clock figures. Assumes one core clock per table clock.
*/
`ifndef LSBD_PARAMS_SVH
`define LSBD_PARAMS_SVH
`define LSBD_OP_ESC 8'h0F
`define LSBD_OP_ITERATE_WHILE_EQUAL_PREFIX 8'hF3
`define LSBD_OP_ITERATE_WHILE_UNEQUAL_PREFIX 8'hF2
`define LSBD_REG_TEST 3'h0
`define LSBD_REG_NOT 3'h2
`define LSBD_REG_BTR 3'h6
`define LSBD_REG_BTC 3'h7
`define LSBD_FAULT_VEC 8'h0D
`define LSBD_T_SHD_R 9'h003
`define LSBD_T_SHD_M 9'h007
`define LSBD_T_TST_R 9'h002
`define LSBD_T_TST_M 9'h005
`define LSBD_T_NOT_M 9'h006
`define LSBD_T_STRING_COMPARE 9'h00A
`define LSBD_T_RCMPS 9'h005
`define LSBD_T_RCMPS_N 9'h009
`define LSBD_T_STRING_COPY 9'h007
`define LSBD_T_STRING_COPY_N 9'h004
`define LSBD_T_STRING_STORE 9'h004
`define LSBD_T_RSTOS 9'h005
`define LSBD_T_STRING_STORE_N 9'h005
`define LSBD_T_INS_RL 9'h00F
`define LSBD_T_INS_LO 9'h009
`define LSBD_T_INS_HI 9'h01D
`define LSBD_T_RINS_RL 9'h00D
`define LSBD_T_RINS_LO 9'h007
`define LSBD_T_RINS_HI 9'h01B
`define LSBD_T_INS_N 9'h006
`define LSBD_T_STRING_PORT_OUTPUT_RL 9'h00E
`define LSBD_T_STRING_PORT_OUTPUT_LO 9'h008
`define LSBD_T_STRING_PORT_OUTPUT_HI 9'h01C
`define LSBD_T_ROUTS_RL 9'h00C
`define LSBD_T_ROUTS_LO 9'h006
`define LSBD_T_ROUTS_HI 9'h01A
`define LSBD_T_STRING_PORT_OUTPUT_N 9'h005
`define LSBD_T_TABLE_LOOKUP_BYTE 9'h005
`define LSBD_T_BT_R 9'h006
`define LSBD_T_BTI_M 9'h008
`define LSBD_T_BTR_M 9'h00D
`define LSBD_T_CALLF_RL 9'h011
`define LSBD_T_CALLF_PR 9'h02A
`define LSBD_T_CALLF_GT 9'h06A
`define LSBD_T_BR 9'h007
`define LSBD_T_BR_NT 9'h003
`define LSBD_T_RETN 9'h00C
`define LSBD_T_RETF 9'h024
`define LSBD_T_RETF_PV 9'h048
`endif

// ===== inc/lsbd_pkg.sv
/*
 Types of the logic, string and branch decoder.
 Assumes lsbd_params.svh is available for constants.
*/
package lsbd_pkg;
	// Decoder states, one-hot
	typedef enum logic [4:0] {
		ST_OP = 5'h01,
		ST_ESC = 5'h02,
		ST_MRM = 5'h04,
		ST_SET = 5'h08,
		ST_ELEM = 5'h10
	} lsbd_state_t;
	// Instruction classes reported
	typedef enum logic [4:0] {
		CL_UNK = 5'h00, CL_SHIFT_LEFT_DOUBLE = 5'h01, CL_SHIFT_RIGHT_DOUBLE = 5'h02,
		CL_TEST = 5'h03, CL_NOT = 5'h04, CL_STRING_COMPARE = 5'h05,
		CL_STRING_COPY = 5'h06, CL_STRING_STORE = 5'h07, CL_INS = 5'h08,
		CL_STRING_PORT_OUTPUT = 5'h09, CL_TABLE_LOOKUP_BYTE = 5'h0A, CL_BTC = 5'h0B,
		CL_BTR = 5'h0C, CL_CALLF = 5'h0D, CL_JMPS = 5'h0E,
		CL_JCC = 5'h0F, CL_RETN = 5'h10, CL_RETF = 5'h11
	} lsbd_cls_t;
	// Processor context sampled when decode completes
	typedef struct packed {
		logic prot;
		logic v86;
		logic [1:0] current_privilege_level;
		logic [1:0] io_privilege_level;
		logic io_deny;
		logic cond_true;
		logic gate_inward;
		logic priv_change;
		logic addr32;
		logic [3:0] next_len;
		logic [4:0] param_cnt;
	} lsbd_ctx_t;
	// Result of one instruction
	typedef struct packed {
		lsbd_cls_t cls;
		logic fault;
		logic [7:0] vec;
		logic [15:0] clocks;
		logic [15:0] elems;
	} lsbd_res_t;
endpackage

// ===== src/lsbd_decoder.sv
/*
 Decoder and clock sequencer for logic, string, bit and branch
 instructions. Takes opcode and mod-reg-r/m bytes from the fetch path
 one byte per clock; immediates and displacements are not presented.
*/
`timescale 1ns/1ps
`include "lsbd_params.svh"
module lsbd_decoder (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Byte stream from fetch
	input wire logic byte_valid,
	input wire logic [7:0] byte_in,
	output logic byte_ready_ff,
	// Context and count
	input wire lsbd_pkg::lsbd_ctx_t ctx,
	input wire logic [31:0] count_in,
	input wire logic elem_equal,
	// Results
	output logic done_ff,
	output lsbd_pkg::lsbd_res_t res_ff,
	output logic [31:0] count_ff
);
	lsbd_pkg::lsbd_state_t state_ff; // Sequencer state
	lsbd_pkg::lsbd_state_t nxt_state; // Next state after byte
	logic take; // Byte accepted
	logic rep_ff; // Repeat prefix seen
	logic rep_eq_ff; // Continue while equal
	logic [7:0] pend_ff; // Opcode waiting for mod-reg-r/m
	logic esc_ff; // Pending opcode came after escape
	logic [8:0] cyc_ff; // Clocks left in current phase
	logic [8:0] base_ff; // Setup clocks
	logic [8:0] per_ff; // Clocks per element
	logic reps_ff; // Repetition active for this one
	logic [15:0] clocks_ff; // Clocks spent so far
	logic [15:0] elems_ff; // Elements done
	lsbd_pkg::lsbd_cls_t cls_ff; // Class being run
	logic fault_ff; // Fault raised
	logic fin; // Decode complete this byte
	logic d_fault; // Decoded fault
	logic d_rep; // Decoded repeatable
	lsbd_pkg::lsbd_cls_t d_cls; // Decoded class
	logic [8:0] d_base; // Decoded setup clocks
	logic [8:0] d_per; // Decoded per-element clocks
	logic [8:0] m9; // Next instruction length
	logic [8:0] x8; // Eight per parameter
	logic mem; // Memory operand
	logic lo_pl; // Privilege within I/O privilege
	logic [2:0] rf; // Reg field
	logic last_cyc; // Final clock of phase
	logic stop; // Repetition ends
	logic [31:0] cnt_dec; // Count after one element

	assign take = byte_valid & byte_ready_ff & ce;
	assign m9 = {5'h00, ctx.next_len};
	assign x8 = {1'b0, ctx.param_cnt, 3'h0};
	assign mem = byte_in[7:6] != 2'h3;
	assign rf = byte_in[5:3];
	assign lo_pl = ctx.current_privilege_level <= ctx.io_privilege_level;
	assign last_cyc = cyc_ff == 9'h001;
	assign cnt_dec = count_ff - 32'h00000001;

	// Opcode decode and timing selection
	always_comb begin
		fin = 1'b0;
		d_fault = 1'b0;
		d_rep = 1'b0;
		d_cls = lsbd_pkg::CL_UNK;
		d_base = 9'h001;
		d_per = 9'h000;
		nxt_state = state_ff;
		case (state_ff)
			lsbd_pkg::ST_OP: begin
				fin = 1'b1;
				casez (byte_in)
					`LSBD_OP_ITERATE_WHILE_EQUAL_PREFIX, `LSBD_OP_ITERATE_WHILE_UNEQUAL_PREFIX: begin
						fin = 1'b0;
					end
					`LSBD_OP_ESC: begin
						fin = 1'b0;
						nxt_state = lsbd_pkg::ST_ESC;
					end
					8'b1000010?, 8'b1111011?: begin
						fin = 1'b0;
						nxt_state = lsbd_pkg::ST_MRM;
					end
					8'b1010100?: begin
						d_cls = lsbd_pkg::CL_TEST;
						d_base = `LSBD_T_TST_R;
					end
					8'b1010011?: begin
						d_cls = lsbd_pkg::CL_STRING_COMPARE;
						d_rep = 1'b1;
						d_base = rep_ff ? `LSBD_T_RCMPS : `LSBD_T_STRING_COMPARE;
						d_per = `LSBD_T_RCMPS_N;
					end
					8'b1010010?: begin
						d_cls = lsbd_pkg::CL_STRING_COPY;
						d_rep = 1'b1;
						d_base = `LSBD_T_STRING_COPY;
						d_per = `LSBD_T_STRING_COPY_N;
					end
					8'b1010101?: begin
						d_cls = lsbd_pkg::CL_STRING_STORE;
						d_rep = 1'b1;
						d_base = rep_ff ? `LSBD_T_RSTOS : `LSBD_T_STRING_STORE;
						d_per = `LSBD_T_STRING_STORE_N;
					end
					8'b0110110?: begin
						d_cls = lsbd_pkg::CL_INS;
						d_rep = 1'b1;
						d_per = `LSBD_T_INS_N;
						if (ctx.v86 && ctx.io_deny) begin
							d_fault = 1'b1;
						end else if (ctx.v86) begin
							d_base = rep_ff ? `LSBD_T_RINS_HI : `LSBD_T_INS_HI;
						end else if (ctx.prot) begin
							d_base = rep_ff ?
								(lo_pl ? `LSBD_T_RINS_LO : `LSBD_T_RINS_HI) :
								(lo_pl ? `LSBD_T_INS_LO : `LSBD_T_INS_HI);
						end else begin
							d_base = rep_ff ? `LSBD_T_RINS_RL : `LSBD_T_INS_RL;
						end
					end
					8'b0110111?: begin
						d_cls = lsbd_pkg::CL_STRING_PORT_OUTPUT;
						d_rep = 1'b1;
						d_per = `LSBD_T_STRING_PORT_OUTPUT_N;
						if (ctx.v86 && ctx.io_deny) begin
							d_fault = 1'b1;
						end else if (ctx.v86) begin
							d_base = rep_ff ? `LSBD_T_ROUTS_HI : `LSBD_T_STRING_PORT_OUTPUT_HI;
						end else if (ctx.prot) begin
							d_base = rep_ff ?
								(lo_pl ? `LSBD_T_ROUTS_LO : `LSBD_T_ROUTS_HI) :
								(lo_pl ? `LSBD_T_STRING_PORT_OUTPUT_LO : `LSBD_T_STRING_PORT_OUTPUT_HI);
						end else begin
							d_base = rep_ff ? `LSBD_T_ROUTS_RL : `LSBD_T_STRING_PORT_OUTPUT_RL;
						end
					end
					8'hD7: begin
						d_cls = lsbd_pkg::CL_TABLE_LOOKUP_BYTE;
						d_base = `LSBD_T_TABLE_LOOKUP_BYTE;
					end
					8'h9A: begin
						d_cls = lsbd_pkg::CL_CALLF;
						if (ctx.prot && ctx.gate_inward) begin
							d_base = `LSBD_T_CALLF_GT + x8 + m9;
						end else begin
							d_base = (ctx.prot ? `LSBD_T_CALLF_PR :
								`LSBD_T_CALLF_RL) + m9;
						end
					end
					8'hEB: begin
						d_cls = lsbd_pkg::CL_JMPS;
						d_base = `LSBD_T_BR + m9;
					end
					8'b0111????: begin
						d_cls = lsbd_pkg::CL_JCC;
						d_base = ctx.cond_true ? `LSBD_T_BR + m9 :
							`LSBD_T_BR_NT;
					end
					8'b1100001?: begin
						d_cls = lsbd_pkg::CL_RETN;
						d_base = `LSBD_T_RETN + m9;
					end
					8'b1100101?: begin
						d_cls = lsbd_pkg::CL_RETF;
						d_base = (ctx.prot && ctx.priv_change) ?
							`LSBD_T_RETF_PV : `LSBD_T_RETF + m9;
					end
					default: begin
						d_cls = lsbd_pkg::CL_UNK;
					end
				endcase
			end
			lsbd_pkg::ST_ESC: begin
				fin = 1'b1;
				casez (byte_in)
					8'hA4, 8'hA5, 8'hAC, 8'hAD, 8'hBA, 8'hBB, 8'hB3: begin
						fin = 1'b0;
						nxt_state = lsbd_pkg::ST_MRM;
					end
					8'b1000????: begin
						d_cls = lsbd_pkg::CL_JCC;
						d_base = ctx.cond_true ? `LSBD_T_BR + m9 :
							`LSBD_T_BR_NT;
					end
					default: begin
						d_cls = lsbd_pkg::CL_UNK;
					end
				endcase
			end
			lsbd_pkg::ST_MRM: begin
				fin = 1'b1;
				case ({esc_ff, pend_ff})
					9'h1A4, 9'h1A5: begin
						d_cls = lsbd_pkg::CL_SHIFT_LEFT_DOUBLE;
						d_base = mem ? `LSBD_T_SHD_M : `LSBD_T_SHD_R;
					end
					9'h1AC, 9'h1AD: begin
						d_cls = lsbd_pkg::CL_SHIFT_RIGHT_DOUBLE;
						d_base = mem ? `LSBD_T_SHD_M : `LSBD_T_SHD_R;
					end
					9'h1BA: begin
						if (rf == `LSBD_REG_BTC) begin
							d_cls = lsbd_pkg::CL_BTC;
						end else if (rf == `LSBD_REG_BTR) begin
							d_cls = lsbd_pkg::CL_BTR;
						end
						d_base = mem ? `LSBD_T_BTI_M : `LSBD_T_BT_R;
						if (d_cls == lsbd_pkg::CL_UNK) begin
							d_base = 9'h001;
						end
					end
					9'h1BB, 9'h1B3: begin
						d_cls = pend_ff[3] ? lsbd_pkg::CL_BTC :
							lsbd_pkg::CL_BTR;
						d_base = mem ? `LSBD_T_BTR_M : `LSBD_T_BT_R;
					end
					9'h084, 9'h085: begin
						d_cls = lsbd_pkg::CL_TEST;
						d_base = mem ? `LSBD_T_TST_M : `LSBD_T_TST_R;
					end
					9'h0F6, 9'h0F7: begin
						if (rf == `LSBD_REG_TEST) begin
							d_cls = lsbd_pkg::CL_TEST;
							d_base = mem ? `LSBD_T_TST_M : `LSBD_T_TST_R;
						end else if (rf == `LSBD_REG_NOT) begin
							d_cls = lsbd_pkg::CL_NOT;
							d_base = mem ? `LSBD_T_NOT_M : `LSBD_T_TST_R;
						end
					end
					default: begin
						d_cls = lsbd_pkg::CL_UNK;
					end
				endcase
			end
			default: begin
				fin = 1'b0;
			end
		endcase
		if (fin) begin
			nxt_state = lsbd_pkg::ST_SET;
		end
		if (d_fault) begin
			d_base = 9'h001;
			d_rep = 1'b0;
		end
	end

	// Repetition ends on zero count or on compare outcome
	assign stop = (cnt_dec == 32'h00000000) ||
		(cls_ff == lsbd_pkg::CL_STRING_COMPARE &&
		(rep_eq_ff ? !elem_equal : elem_equal));

	// State sequencing
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= lsbd_pkg::ST_OP;
		end else if (ce) begin
			if (take) begin
				state_ff <= nxt_state;
			end else if (state_ff == lsbd_pkg::ST_SET && last_cyc) begin
				state_ff <= reps_ff ? lsbd_pkg::ST_ELEM : lsbd_pkg::ST_OP;
			end else if (state_ff == lsbd_pkg::ST_ELEM && last_cyc && stop) begin
				state_ff <= lsbd_pkg::ST_OP;
			end
		end
	end

	// Ready to take a byte in the decode states only
	always_ff @(posedge clk) begin
		if (rst) begin
			byte_ready_ff <= 1'b1;
		end else if (ce) begin
			if (take) begin
				byte_ready_ff <= !fin;
			end else if ((state_ff == lsbd_pkg::ST_SET && last_cyc &&
				!reps_ff) || (state_ff == lsbd_pkg::ST_ELEM && last_cyc &&
				stop)) begin
				byte_ready_ff <= 1'b1;
			end
		end
	end

	// Prefix and pending opcode capture
	always_ff @(posedge clk) begin
		if (rst) begin
			rep_ff <= 1'b0;
			rep_eq_ff <= 1'b0;
			pend_ff <= 8'h00;
			esc_ff <= 1'b0;
		end else if (ce && take) begin
			if (state_ff == lsbd_pkg::ST_OP &&
				(byte_in == `LSBD_OP_ITERATE_WHILE_EQUAL_PREFIX || byte_in == `LSBD_OP_ITERATE_WHILE_UNEQUAL_PREFIX)) begin
				rep_ff <= 1'b1;
				rep_eq_ff <= byte_in == `LSBD_OP_ITERATE_WHILE_EQUAL_PREFIX;
			end else if (fin) begin
				rep_ff <= 1'b0;
			end
			if (nxt_state == lsbd_pkg::ST_MRM) begin
				pend_ff <= byte_in;
				esc_ff <= state_ff == lsbd_pkg::ST_ESC;
			end
		end
	end

	// Cycle counting of setup and element phases
	always_ff @(posedge clk) begin
		if (rst) begin
			cyc_ff <= 9'h000;
			base_ff <= 9'h000;
			per_ff <= 9'h000;
			clocks_ff <= 16'h0000;
			cls_ff <= lsbd_pkg::CL_UNK;
			fault_ff <= 1'b0;
		end else if (ce) begin
			if (take && fin) begin
				cyc_ff <= d_base;
				base_ff <= d_base;
				per_ff <= d_per;
				clocks_ff <= 16'h0000;
				cls_ff <= d_cls;
				fault_ff <= d_fault;
			end else if (state_ff == lsbd_pkg::ST_SET ||
				state_ff == lsbd_pkg::ST_ELEM) begin
				clocks_ff <= clocks_ff + 16'h0001;
				cyc_ff <= last_cyc ? per_ff : cyc_ff - 9'h001;
			end
		end
	end

	// Count register and element tally
	always_ff @(posedge clk) begin
		if (rst) begin
			count_ff <= 32'h00000000;
			elems_ff <= 16'h0000;
			reps_ff <= 1'b0;
		end else if (ce) begin
			if (take && fin) begin
				count_ff <= ctx.addr32 ? count_in :
					{16'h0000, count_in[15:0]};
				reps_ff <= rep_ff && d_rep &&
					(ctx.addr32 ? count_in != 32'h00000000 :
					count_in[15:0] != 16'h0000);
				elems_ff <= 16'h0000;
			end else if (state_ff == lsbd_pkg::ST_ELEM && last_cyc) begin
				count_ff <= cnt_dec;
				elems_ff <= elems_ff + 16'h0001;
			end
		end
	end

	// Completion pulse and result
	always_ff @(posedge clk) begin
		if (rst) begin
			done_ff <= 1'b0;
			res_ff <= '0;
		end else if (ce) begin
			done_ff <= 1'b0;
			if ((state_ff == lsbd_pkg::ST_SET && last_cyc && !reps_ff) ||
				(state_ff == lsbd_pkg::ST_ELEM && last_cyc && stop)) begin
				done_ff <= 1'b1;
				res_ff.cls <= cls_ff;
				res_ff.fault <= fault_ff;
				res_ff.vec <= fault_ff ? `LSBD_FAULT_VEC : 8'h00;
				res_ff.clocks <= clocks_ff + 16'h0001;
				res_ff.elems <= elems_ff +
					{15'h0000, state_ff == lsbd_pkg::ST_ELEM};
			end
		end
	end

	// Total equals setup plus elements times per-element clocks
	property p_total;
		@(posedge clk) disable iff (rst)
		$rose(done_ff) |-> res_ff.clocks ==
			16'(base_ff) + 16'(per_ff) * res_ff.elems;
	endproperty
	a_total: assert property (p_total) else $error("clock total wrong");
	property p_done_pulse;
		@(posedge clk) disable iff (rst)
		done_ff && ce |=> !done_ff;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done held");
	property p_fault_vec;
		@(posedge clk) disable iff (rst)
		$rose(done_ff) && res_ff.fault |-> res_ff.vec == 8'h0D &&
			res_ff.clocks == 16'h0001;
	endproperty
	a_fault_vec: assert property (p_fault_vec) else $error("fault vector bad");
	property p_count_dec;
		@(posedge clk) disable iff (rst)
		ce && state_ff == lsbd_pkg::ST_ELEM && last_cyc |=>
			count_ff == $past(count_ff) - 32'h00000001;
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("count not decremented");
	property p_table_lookup_byte;
		@(posedge clk) disable iff (rst)
		$rose(done_ff) && res_ff.cls == lsbd_pkg::CL_TABLE_LOOKUP_BYTE |->
			res_ff.clocks == 16'h0005;
	endproperty
	a_table_lookup_byte: assert property (p_table_lookup_byte) else $error("lookup clocks bad");
	property p_retf;
		@(posedge clk) disable iff (rst)
		ce && take && fin && state_ff == lsbd_pkg::ST_OP &&
			byte_in == 8'hCB && ctx.prot && ctx.priv_change |=>
			base_ff == 9'h048;
	endproperty
	a_retf: assert property (p_retf) else $error("far exit clocks bad");
	property p_jcc_nt;
		@(posedge clk) disable iff (rst)
		ce && take && state_ff == lsbd_pkg::ST_OP && byte_in[7:4] == 4'h7 &&
			!ctx.cond_true |=> base_ff == 9'h003 && cls_ff == lsbd_pkg::CL_JCC;
	endproperty
	a_jcc_nt: assert property (p_jcc_nt) else $error("fall-through clocks bad");
	property p_ready;
		@(posedge clk) disable iff (rst)
		state_ff == lsbd_pkg::ST_SET || state_ff == lsbd_pkg::ST_ELEM |->
			!byte_ready_ff;
	endproperty
	a_ready: assert property (p_ready) else $error("ready while busy");
endmodule // lsbd_decoder

// ===== verif/lsbd_fetch_model.sv
/*
 Fetch-side model: offers opcode bytes one at a time and holds each
 until the decoder takes it. Assumes the bench calls send once at a time.
*/
`timescale 1ns/1ps
module lsbd_fetch_model (
	// Clock and enable
	input wire logic clk,
	input wire logic ce,
	// Byte offer
	input wire logic byte_ready,
	output logic byte_valid,
	output logic [7:0] byte_in
);
	logic rel; // Release request after a take
	initial begin
		byte_valid = 1'b0;
		byte_in = 8'hA5;
		rel = 1'b0;
	end
	// Idle lines toggle so a stale byte is never mistaken for data
	always @(negedge clk) begin
		if (rel) begin
			byte_valid = 1'b0;
			rel = 1'b0;
		end
		if (!byte_valid) begin
			byte_in = ~byte_in;
		end
	end
	// Offer n bytes, optional idle gap, hold each until taken
	task automatic send(input logic [23:0] b, input int n, input int gap,
		output logic ok);
		int w;
		ok = 1'b1;
		for (int i = 0; i < n; i++) begin
			repeat (gap) @(negedge clk);
			@(negedge clk);
			#1;
			byte_valid = 1'b1;
			byte_in = b[23 - 8 * i -: 8];
			w = 0;
			while (!(byte_ready === 1'b1 && ce === 1'b1) && w < 64) begin
				@(negedge clk);
				w++;
			end
			ok = ok & (w < 64);
			@(posedge clk);
			if (gap > 0 || i == n - 1) begin
				rel = 1'b1;
			end
		end
	endtask
endmodule // lsbd_fetch_model

// ===== verif/tb_top.sv
/*
 Self-checking bench for the decoder: each task runs one kind of
 instruction and checks class, clocks, fault and timing of done, and count after repeated strings.
 Assumes the fetch model drives the byte stream.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
	n_fail++; $display("mismatch t=%0t got %0h exp %0h", $time, got, exp); \
	end end
module tb_top;
	// Clock, reset, enable
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	// Fetch and context
	logic byte_valid;
	logic [7:0] byte_in;
	logic byte_ready_ff;
	lsbd_pkg::lsbd_ctx_t ctx = '0;
	logic [31:0] count_in = 32'h00000000;
	logic elem_equal = 1'b0;
	// Results
	logic done_ff;
	lsbd_pkg::lsbd_res_t res_ff;
	logic [31:0] count_ff;
	int n_fail = 0; // Mismatches
	int num_checks = 0; // Comparisons
	int gap = 0; // Fetch idle cycles per byte
	logic [15:0] hold = 16'h0000; // Cycles with ce low
	logic [15:0] m; // Next instruction length
	logic [15:0] e_na = 16'hFFFF; // Element count not checked
	initial forever #2.5 clk = ~clk;
	lsbd_decoder u_lsbd_decoder (.clk(clk), .rst(rst), .ce(ce),
		.byte_valid(byte_valid), .byte_in(byte_in),
		.byte_ready_ff(byte_ready_ff), .ctx(ctx), .count_in(count_in),
		.elem_equal(elem_equal), .done_ff(done_ff), .res_ff(res_ff),
		.count_ff(count_ff));
	lsbd_fetch_model u_lsbd_fetch_model (.clk(clk), .ce(ce),
		.byte_ready(byte_ready_ff), .byte_valid(byte_valid),
		.byte_in(byte_in));
	// Verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Run one instruction, check result and its timing
	task automatic op(input logic [23:0] b, input int n,
		input lsbd_pkg::lsbd_cls_t c, input logic [15:0] t,
		input logic [15:0] e, input logic f);
		logic ok;
		int k;
		u_lsbd_fetch_model.send(b, n, gap, ok);
		k = 0;
		do begin
			@(posedge clk);
			k++;
			@(negedge clk);
			// Ready stays low until the done edge; a 1-clock op is done here
			if (k == 1) `CHK(byte_ready_ff, 1'(t == 16'h0001))
		end while (done_ff !== 1'b1 && k < 400);
		if (!ok || k >= 400) begin
			n_fail++;
			conclude();
		end
		// Done is registered on the t-th enabled edge after the take edge
		`CHK(16'(k), t + hold)
		`CHK(res_ff.cls, c)
		`CHK(res_ff.clocks, t)
		`CHK(res_ff.fault, f)
		if (e !== e_na) `CHK(res_ff.elems, e)
		@(negedge clk);
		`CHK(done_ff, 1'b0)
	endtask
	// Double shifts, register and memory forms
	task automatic t_shift();
		op(24'h0FA4C0, 3, lsbd_pkg::CL_SHIFT_LEFT_DOUBLE, 16'h0003, e_na, 1'b0);
		op(24'h0FA500, 3, lsbd_pkg::CL_SHIFT_LEFT_DOUBLE, 16'h0007, e_na, 1'b0);
		op(24'h0FACC0, 3, lsbd_pkg::CL_SHIFT_RIGHT_DOUBLE, 16'h0003, e_na, 1'b0);
		op(24'h0FAD00, 3, lsbd_pkg::CL_SHIFT_RIGHT_DOUBLE, 16'h0007, e_na, 1'b0);
	endtask
	// Flag-only AND and inversion
	task automatic t_logic();
		op(24'h85C000, 2, lsbd_pkg::CL_TEST, 16'h0002, e_na, 1'b0);
		op(24'hF70000, 2, lsbd_pkg::CL_TEST, 16'h0005, e_na, 1'b0);
		op(24'hA80000, 1, lsbd_pkg::CL_TEST, 16'h0002, e_na, 1'b0);
		op(24'hF7D000, 2, lsbd_pkg::CL_NOT, 16'h0002, e_na, 1'b0);
		op(24'hF61000, 2, lsbd_pkg::CL_NOT, 16'h0006, e_na, 1'b0);
	endtask
	// Repeated strings, stop by count and by compare outcome
	task automatic t_rep();
		gap = 2;
		count_in = 32'h00000003;
		elem_equal = 1'b1;
		op(24'hF3A700, 2, lsbd_pkg::CL_STRING_COMPARE, 16'h0020, 16'h0003, 1'b0);
		`CHK(count_ff, 32'h00000000)
		count_in = 32'h00000004;
		op(24'hF2A600, 2, lsbd_pkg::CL_STRING_COMPARE, 16'h000E, 16'h0001, 1'b0);
		`CHK(count_ff, 32'h00000003)
		gap = 0;
		count_in = 32'h00010002;
		op(24'hF3A500, 2, lsbd_pkg::CL_STRING_COPY, 16'h000F, 16'h0002, 1'b0);
		`CHK(count_ff[15:0], 16'h0000)
		ctx.addr32 = 1'b1;
		count_in = 32'h00000003;
		op(24'hF3A500, 2, lsbd_pkg::CL_STRING_COPY, 16'h0013, 16'h0003, 1'b0);
		// Upper count half only: the 32-bit count must not read as zero
		count_in = 32'h00010000;
		op(24'hF2A700, 2, lsbd_pkg::CL_STRING_COMPARE, 16'h000E, 16'h0001, 1'b0);
		`CHK(count_ff, 32'h0000FFFF)
		count_in = 32'h00000004;
		op(24'hF3AB00, 2, lsbd_pkg::CL_STRING_STORE, 16'h0019, 16'h0004, 1'b0);
		count_in = 32'h00000000;
		op(24'hF3AB00, 2, lsbd_pkg::CL_STRING_STORE, 16'h0005, 16'h0000, 1'b0);
		ctx.addr32 = 1'b0;
	endtask
	// Port strings in real mode and in protected mode at privilege 0 and 3, then bitmap fault
	task automatic t_port();
		logic [15:0] ti [3];
		logic [15:0] to [3];
		ti = '{16'h000F, 16'h0009, 16'h001D};
		to = '{16'h000E, 16'h0008, 16'h001C};
		for (int i = 0; i < 3; i++) begin
			ctx.prot = (i > 0);
			ctx.current_privilege_level = (i == 2) ? 2'h3 : 2'h0;
			op(24'h6C0000, 1, lsbd_pkg::CL_INS, ti[i], e_na, 1'b0);
			op(24'h6E0000, 1, lsbd_pkg::CL_STRING_PORT_OUTPUT, to[i], e_na, 1'b0);
		end
		ctx.v86 = 1'b1;
		ctx.io_deny = 1'b1;
		op(24'h6D0000, 1, lsbd_pkg::CL_INS, 16'h0001, e_na, 1'b1);
		`CHK(res_ff.vec, 8'h0D)
		ctx = '0;
	endtask
	// Table lookup and bit test-and-modify
	task automatic t_bits();
		op(24'hD70000, 1, lsbd_pkg::CL_TABLE_LOOKUP_BYTE, 16'h0005, e_na, 1'b0);
		op(24'h0FBAF8, 3, lsbd_pkg::CL_BTC, 16'h0006, e_na, 1'b0);
		op(24'h0FBA38, 3, lsbd_pkg::CL_BTC, 16'h0008, e_na, 1'b0);
		op(24'h0FBBC0, 3, lsbd_pkg::CL_BTC, 16'h0006, e_na, 1'b0);
		op(24'h0FBB00, 3, lsbd_pkg::CL_BTC, 16'h000D, e_na, 1'b0);
		op(24'h0FBAF0, 3, lsbd_pkg::CL_BTR, 16'h0006, e_na, 1'b0);
		op(24'h0FB3C0, 3, lsbd_pkg::CL_BTR, 16'h0006, e_na, 1'b0);
		op(24'h0FB300, 3, lsbd_pkg::CL_BTR, 16'h000D, e_na, 1'b0);
		op(24'h0FBAE0, 3, lsbd_pkg::CL_UNK, 16'h0001, e_na, 1'b0);
	endtask
	// Far calls, short branch and exits with next length m
	task automatic t_xfer();
		ctx.next_len = 4'h3;
		m = 16'h0003;
		op(24'h9A0000, 1, lsbd_pkg::CL_CALLF, 16'h0011 + m, e_na, 1'b0);
		ctx.prot = 1'b1;
		op(24'h9A0000, 1, lsbd_pkg::CL_CALLF, 16'h002A + m, e_na, 1'b0);
		ctx.gate_inward = 1'b1;
		ctx.param_cnt = 5'h02;
		op(24'h9A0000, 1, lsbd_pkg::CL_CALLF, 16'h007D, e_na, 1'b0);
		for (int i = 2; i < 6; i += 3) begin
			ctx.next_len = i[3:0];
			m = 16'(i);
			op(24'hEB0000, 1, lsbd_pkg::CL_JMPS, 16'h0007 + m, e_na, 1'b0);
		end
		ctx.prot = 1'b0;
		op(24'hC20000, 1, lsbd_pkg::CL_RETN, 16'h000C + m, e_na, 1'b0);
		ctx.prot = 1'b1;
		ctx.priv_change = 1'b1;
		op(24'hCA0000, 1, lsbd_pkg::CL_RETF, 16'h0048, e_na, 1'b0);
		op(24'hCB0000, 1, lsbd_pkg::CL_RETF, 16'h0048, e_na, 1'b0);
		ctx = '0;
	endtask
	// Every condition code, short and escaped, taken and not taken
	task automatic t_jcc();
		ctx.next_len = 4'h4;
		m = 16'h0004;
		for (int i = 0; i < 32; i++) begin
			ctx.cond_true = i[4];
			op({8'h70 + 8'(i[3:0]), 16'h0000}, 1, lsbd_pkg::CL_JCC,
				i[4] ? 16'h0007 + m : 16'h0003, e_na, 1'b0);
			op({8'h0F, 8'h80 + 8'(i[3:0]), 8'h00}, 2, lsbd_pkg::CL_JCC,
				i[4] ? 16'h0007 + m : 16'h0003, e_na, 1'b0);
		end
		ctx = '0;
	endtask
	// Clock enable low stretches the count by the frozen cycles
	task automatic t_freeze();
		ctx.next_len = 4'h2;
		hold = 16'h0003;
		fork
			op(24'hEB0000, 1, lsbd_pkg::CL_JMPS, 16'h0009, e_na, 1'b0);
			begin
				repeat (4) @(negedge clk);
				ce = 1'b0;
				repeat (3) @(negedge clk);
				ce = 1'b1;
			end
		join
		hold = 16'h0000;
		ctx = '0;
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		`CHK(byte_ready_ff, 1'b1)
		`CHK(done_ff, 1'b0)
		`CHK(res_ff, '0)
		`CHK(count_ff, 32'h00000000)
		t_shift();
		t_logic();
		t_rep();
		t_port();
		t_bits();
		t_xfer();
		t_jcc();
		t_freeze();
		conclude();
	end
endmodule // tb_top
